// File: tpf_defines.vh
`ifndef TPF_DEFINES_VH
`define TPF_DEFINES_VH

// Register byte addresses
`define TPF_ADDR_TX_ENABLE_A   8'h0A
`define TPF_ADDR_TX_ENABLE_B   8'h10
`define TPF_ADDR_LEN_HIGH      8'h11
`define TPF_ADDR_LEN_LOW       8'h12
`define TPF_ADDR_FIFO_PORT     8'h13
`define TPF_ADDR_DONE_COUNT_HI 8'h14
`define TPF_ADDR_COUNT_LOW     8'h15
`define TPF_ADDR_FIFO_STATUS   8'h16
`define TPF_ADDR_SOFT_RESET    8'h17

// Field positions
`define TPF_BIT_TX_ENABLE      2
`define TPF_BIT_LEN_MODE       7
`define TPF_BIT_SOFT_RESET     0

// Reset values
`define TPF_RST_LEN_HIGH       8'h00
`define TPF_RST_LEN_LOW        8'hFF
`define TPF_RST_FIFO_PORT      8'h00

// FIFO geometry
`define TPF_FIFO_DEPTH         3'h7
`define TPF_FIFO_LAST          3'h6

// Serial target address, arbitrary value
`define TPF_TARGET_ADDR        7'h2A

// Serial engine states
`define TPF_ST_IDLE            3'h0
`define TPF_ST_DEV             3'h1
`define TPF_ST_REG             3'h2
`define TPF_ST_WR              3'h3
`define TPF_ST_ACK             3'h4
`define TPF_ST_RD              3'h5
`define TPF_ST_MACK            3'h6

`endif

// File: tpf_sync.v
`timescale 1ns/1ps
module tpf_sync
(
   input  wire i_clk,   // Core clock
   input  wire i_rst,   // Sync reset, high
   input  wire i_async, // Signal from outside the domain
   output reg  o_sync   // Synchronised level
);
   reg meta;

   always @(posedge i_clk)
   begin
      if (i_rst)
      begin
         meta   <= 1'b1;
         o_sync <= 1'b1;
      end
      else
      begin
         meta   <= i_async;
         o_sync <= meta;
      end
   end
endmodule // tpf_sync

// File: tpf_tx_fifo.v
`timescale 1ns/1ps
`include "tpf_defines.vh"
// What this block does
// [RULE1] Mode clear: underflow ends the packet
// [RULE2] Host pads long underflow-ended packets to bytes
// [RULE3] Mode set: end after programmed bits or underflow
// [RULE4] FIFO port writes push; address never advances
// [RULE5] Read-only done flag set at packet end
// [RULE6] Read-only 15-bit sent count, split registers
// [RULE7] Read-only 3-bit FIFO fill count
// [RULE8] Each FIFO location holds one byte
// [RULE9] Soft reset bit holds logic until cleared
// [RULE10] Transmit starts only while enable bit set
// [RULE11] Underflow, overflow flags; empty after reset
// [RULE12] Seven-byte FIFO, full when all occupied
module tpf_tx_fifo
(
   input  wire i_clk,       // 20 MHz core clock
   input  wire i_rst,       // Sync reset, high
   input  wire i_scl,       // Serial clock pin
   input  wire i_sda,       // Serial data pin level
   output reg  o_sda_out,   // Serial data drive value
   output reg  o_sda_oe,    // Serial data drive enable
   input  wire i_bit_req,   // Modulator wants next bit
   output reg  o_tx_bit,    // Bit to modulate
   output reg  o_bit_valid, // One-cycle bit strobe
   output reg  o_tx_active  // Packet in progress
);
   wire       scl_s;
   wire       sda_s;
   reg        scl_q;
   reg        sda_q;
   reg  [2:0] state;
   reg  [2:0] after_ack;
   reg  [3:0] bitcnt;
   reg  [7:0] sr;
   reg  [7:0] ptr;
   reg        wr_stb;
   reg  [7:0] wr_addr;
   reg  [7:0] wr_data;
   reg        soft_rst;
   reg  [7:0] len_high;
   reg  [7:0] len_low;
   reg  [7:0] port_last;
   reg        tx_enable;
   reg  [7:0] fifo_mem [0:6];
   reg  [2:0] wptr;
   reg  [2:0] rptr;
   reg  [2:0] count;
   reg        underrun;
   reg        overrun;
   reg        done;
   reg [14:0] sent;
   reg  [7:0] shreg;
   reg  [2:0] bits_left;
   reg  [7:0] rd_data;
   wire       core_rst;
   wire       scl_rise;
   wire       scl_fall;
   wire       start_cond;
   wire       stop_cond;
   wire       empty;
   wire       full;
   wire       push;
   wire       pop;
   wire       need_byte;
   wire       len_mode;
   wire [14:0] pkt_len;
   wire [14:0] sent_next;

   tpf_sync u_sync_scl
   (
      .i_clk   (i_clk),
      .i_rst   (i_rst),
      .i_async (i_scl),
      .o_sync  (scl_s)
   );

   tpf_sync u_sync_sda
   (
      .i_clk   (i_clk),
      .i_rst   (i_rst),
      .i_async (i_sda),
      .o_sync  (sda_s)
   );

   assign core_rst   = i_rst | soft_rst;                            // [RULE9]
   assign scl_rise   = scl_s & ~scl_q;
   assign scl_fall   = ~scl_s & scl_q;
   assign start_cond = scl_s & scl_q & sda_q & ~sda_s;
   assign stop_cond  = scl_s & scl_q & ~sda_q & sda_s;
   assign empty      = (count == 3'h0);
   assign full       = (count == `TPF_FIFO_DEPTH);                  // [RULE12]
   assign len_mode   = len_high[`TPF_BIT_LEN_MODE];
   assign pkt_len    = {len_high[6:0], len_low};
   assign sent_next  = sent + 15'h0001;
   assign push       = wr_stb && (wr_addr == `TPF_ADDR_FIFO_PORT) && !full; // [RULE4]
   assign need_byte  = (bits_left == 3'h0);
   assign pop        = o_tx_active && i_bit_req && need_byte && !empty &&
                       !(len_mode && (pkt_len == 15'h0000));

   always @*
   begin
      case (ptr)
         `TPF_ADDR_TX_ENABLE_A:   rd_data = {5'h00, tx_enable, 2'h0};
         `TPF_ADDR_TX_ENABLE_B:   rd_data = {5'h00, tx_enable, 2'h0};
         `TPF_ADDR_LEN_HIGH:      rd_data = len_high;
         `TPF_ADDR_LEN_LOW:       rd_data = len_low;
         `TPF_ADDR_FIFO_PORT:     rd_data = port_last;
         `TPF_ADDR_DONE_COUNT_HI: rd_data = {done, sent[14:8]};          // [RULE5] [RULE6]
         `TPF_ADDR_COUNT_LOW:     rd_data = sent[7:0];                   // [RULE6]
         `TPF_ADDR_FIFO_STATUS:   rd_data = {underrun, overrun, empty, full, 1'b0, count}; // [RULE7]
         `TPF_ADDR_SOFT_RESET:    rd_data = {7'h00, soft_rst};
         default:                 rd_data = 8'h00;
      endcase
   end

   // Serial target; survives soft reset so the bit can be cleared again
   always @(posedge i_clk)
   begin
      if (i_rst)
      begin
         scl_q     <= 1'b1;
         sda_q     <= 1'b1;
         state     <= `TPF_ST_IDLE;
         after_ack <= `TPF_ST_IDLE;
         bitcnt    <= 4'h0;
         sr        <= 8'h00;
         ptr       <= 8'h00;
         wr_stb    <= 1'b0;
         wr_addr   <= 8'h00;
         wr_data   <= 8'h00;
         o_sda_out <= 1'b0;
         o_sda_oe  <= 1'b0;
      end
      else
      begin
         scl_q     <= scl_s;
         sda_q     <= sda_s;
         wr_stb    <= 1'b0;
         o_sda_out <= 1'b0;
         if (start_cond)
         begin
            state    <= `TPF_ST_DEV;
            bitcnt   <= 4'h0;
            o_sda_oe <= 1'b0;
         end
         else if (stop_cond)
         begin
            state    <= `TPF_ST_IDLE;
            o_sda_oe <= 1'b0;
         end
         else
         begin
            case (state)
               `TPF_ST_DEV, `TPF_ST_REG, `TPF_ST_WR:
               begin
                  if (scl_rise)
                  begin
                     sr     <= {sr[6:0], sda_s};
                     bitcnt <= bitcnt + 4'h1;
                  end
                  else if (scl_fall && (bitcnt == 4'h8))
                  begin
                     bitcnt <= 4'h0;
                     if (state == `TPF_ST_DEV)
                     begin
                        if (sr[7:1] == `TPF_TARGET_ADDR)
                        begin
                           o_sda_oe  <= 1'b1;
                           state     <= `TPF_ST_ACK;
                           after_ack <= sr[0] ? `TPF_ST_RD : `TPF_ST_REG;
                        end
                        else
                           state <= `TPF_ST_IDLE;
                     end
                     else if (state == `TPF_ST_REG)
                     begin
                        ptr       <= sr;
                        o_sda_oe  <= 1'b1;
                        state     <= `TPF_ST_ACK;
                        after_ack <= `TPF_ST_WR;
                     end
                     else
                     begin
                        wr_stb    <= 1'b1;
                        wr_addr   <= ptr;
                        wr_data   <= sr;
                        if (ptr != `TPF_ADDR_FIFO_PORT)                 // [RULE4]
                           ptr <= ptr + 8'h01;
                        o_sda_oe  <= 1'b1;
                        state     <= `TPF_ST_ACK;
                        after_ack <= `TPF_ST_WR;
                     end
                  end
               end
               `TPF_ST_ACK:
               begin
                  if (scl_fall)
                  begin
                     bitcnt <= 4'h0;
                     state  <= after_ack;
                     if (after_ack == `TPF_ST_RD)
                     begin
                        sr       <= rd_data;
                        o_sda_oe <= ~rd_data[7];
                        if (ptr != `TPF_ADDR_FIFO_PORT)
                           ptr <= ptr + 8'h01;
                     end
                     else
                        o_sda_oe <= 1'b0;
                  end
               end
               `TPF_ST_RD:
               begin
                  if (scl_fall)
                  begin
                     if (bitcnt == 4'h7)
                     begin
                        o_sda_oe <= 1'b0;
                        state    <= `TPF_ST_MACK;
                     end
                     else
                     begin
                        sr       <= {sr[6:0], 1'b0};
                        o_sda_oe <= ~sr[6];
                        bitcnt   <= bitcnt + 4'h1;
                     end
                  end
               end
               `TPF_ST_MACK:
               begin
                  if (scl_rise)
                  begin
                     after_ack <= `TPF_ST_RD;
                     state     <= sda_s ? `TPF_ST_IDLE : `TPF_ST_ACK;
                  end
               end
               default:
                  state <= `TPF_ST_IDLE;
            endcase
         end
      end
   end

   always @(posedge i_clk)
   begin
      if (i_rst)
         soft_rst <= 1'b0;
      else if (wr_stb && (wr_addr == `TPF_ADDR_SOFT_RESET))
         soft_rst <= wr_data[`TPF_BIT_SOFT_RESET];                      // [RULE9]
   end

   // Configuration; writes are dropped while soft reset holds
   always @(posedge i_clk)
   begin
      if (core_rst)
      begin
         len_high  <= `TPF_RST_LEN_HIGH;
         len_low   <= `TPF_RST_LEN_LOW;
         port_last <= `TPF_RST_FIFO_PORT;
         tx_enable <= 1'b0;
      end
      else if (wr_stb)
      begin
         case (wr_addr)
            `TPF_ADDR_LEN_HIGH:    len_high  <= wr_data;
            `TPF_ADDR_LEN_LOW:     len_low   <= wr_data;
            `TPF_ADDR_FIFO_PORT:   port_last <= wr_data;
            `TPF_ADDR_TX_ENABLE_A: tx_enable <= wr_data[`TPF_BIT_TX_ENABLE]; // [RULE10]
            `TPF_ADDR_TX_ENABLE_B: tx_enable <= wr_data[`TPF_BIT_TX_ENABLE]; // [RULE10]
            default:               tx_enable <= tx_enable;
         endcase
      end
   end

   // Byte-wide FIFO storage
   always @(posedge i_clk)
   begin
      if (push)
         fifo_mem[wptr] <= wr_data;                                     // [RULE8]
   end

   always @(posedge i_clk)
   begin
      if (core_rst)
      begin
         wptr     <= 3'h0;
         rptr     <= 3'h0;
         count    <= 3'h0;                                              // [RULE11]
         overrun  <= 1'b0;
      end
      else
      begin
         if (push)
            wptr <= (wptr == `TPF_FIFO_LAST) ? 3'h0 : wptr + 3'h1;
         if (pop)
            rptr <= (rptr == `TPF_FIFO_LAST) ? 3'h0 : rptr + 3'h1;
         if (push && !pop)
            count <= count + 3'h1;                                      // [RULE7]
         else if (pop && !push)
            count <= count - 3'h1;
         if (wr_stb && (wr_addr == `TPF_ADDR_FIFO_PORT) && full)
            overrun <= 1'b1;                                            // [RULE11]
      end
   end

   // Bit serialiser, MSB first
   always @(posedge i_clk)
   begin
      if (core_rst)
      begin
         o_tx_active <= 1'b0;
         o_tx_bit    <= 1'b0;
         o_bit_valid <= 1'b0;
         underrun    <= 1'b0;
         done        <= 1'b0;
         sent        <= 15'h0000;
         shreg       <= 8'h00;
         bits_left   <= 3'h0;
      end
      else
      begin
         o_bit_valid <= 1'b0;
         if (!o_tx_active)
         begin
            if (tx_enable && !empty)                                    // [RULE10]
            begin
               o_tx_active <= 1'b1;
               done        <= 1'b0;
               sent        <= 15'h0000;
               bits_left   <= 3'h0;
            end
         end
         else if (i_bit_req)
         begin
            if (len_mode && (pkt_len == 15'h0000))
            begin
               o_tx_active <= 1'b0;                                     // [RULE3]
               done        <= 1'b1;
            end
            else if (need_byte && empty)
            begin
               underrun    <= 1'b1;                                     // [RULE11]
               o_tx_active <= 1'b0;                                     // [RULE1] [RULE3]
               done        <= 1'b1;                                     // [RULE5]
            end
            else
            begin
               o_bit_valid <= 1'b1;
               sent        <= sent_next;                                // [RULE6]
               if (need_byte)
               begin
                  o_tx_bit  <= fifo_mem[rptr][7];
                  shreg     <= {fifo_mem[rptr][6:0], 1'b0};
                  bits_left <= 3'h7;
               end
               else
               begin
                  o_tx_bit  <= shreg[7];
                  shreg     <= {shreg[6:0], 1'b0};
                  bits_left <= bits_left - 3'h1;
               end
               if (len_mode && (sent_next == pkt_len))
               begin
                  o_tx_active <= 1'b0;                                  // [RULE3]
                  done        <= 1'b1;                                  // [RULE5]
               end
            end
         end
      end
   end
endmodule // tpf_tx_fifo

// File: tpf_tx_fifo_props.sv
`timescale 1ns/1ps
module tpf_tx_fifo_props
(
   input wire i_clk,       // Core clock
   input wire i_rst,       // Sync reset, high
   input wire i_scl,       // Serial clock pin
   input wire i_sda,       // Serial data level
   input wire o_sda_out,   // Data drive value
   input wire o_sda_oe,    // Data drive enable
   input wire i_bit_req,   // Bit request
   input wire o_tx_bit,    // Bit out
   input wire o_bit_valid, // Bit strobe
   input wire o_tx_active  // Packet running
);
   default clocking @(posedge i_clk);
   endclocking
   default disable iff (i_rst);

   sequence s_req_live;
      i_bit_req && o_tx_active;
   endsequence

   sequence s_bit_out;
      o_bit_valid ##1 !o_bit_valid;
   endsequence

   a_valid_needs_req: assert property (o_bit_valid |-> $past(i_bit_req) && $past(o_tx_active))
      else $error("bit strobe without live request");
   a_idle_no_bits: assert property (i_bit_req && !o_tx_active |=> !o_bit_valid)
      else $error("bit sent while idle");
   a_req_answered: assert property (s_req_live |=> o_bit_valid || !o_tx_active)
      else $error("request neither served nor ending");
   a_end_on_request: assert property ($fell(o_tx_active) |-> o_bit_valid || $past(i_bit_req))
      else $error("packet ended without a request");
   // Bit must survive until the modulator has used it
   a_bit_holds: assert property (s_bit_out |-> $stable(o_tx_bit))
      else $error("bit value moved after strobe");
   a_oe_scl_low: assert property ($changed(o_sda_oe) |-> !i_scl)
      else $error("data line moved while clock high");
   a_drive_held: assert property ($rose(o_sda_oe) |=> o_sda_oe[*4])
      else $error("data drive too short");
   a_open_drain: assert property (o_sda_out == 1'b0)
      else $error("data drive value not low");
endmodule // tpf_tx_fifo_props

bind tpf_tx_fifo tpf_tx_fifo_props u_props
(
   .i_clk(i_clk), .i_rst(i_rst), .i_scl(i_scl), .i_sda(i_sda), .o_sda_out(o_sda_out),
   .o_sda_oe(o_sda_oe), .i_bit_req(i_bit_req), .o_tx_bit(o_tx_bit),
   .o_bit_valid(o_bit_valid), .o_tx_active(o_tx_active)
);

// File: tpf_host_model.sv
`timescale 1ns/1ps
module tpf_host_model
(
   input  wire i_sda,    // Wire level
   output reg  o_scl,    // Serial clock, idles high
   output reg  o_sda_oe  // High pulls data low
);
   initial
   begin
      o_scl = 1'b1;
      o_sda_oe = 1'b0;
   end

   // Long low phase leaves room for the target's synchroniser delay
   task start;
   begin
      #140 o_sda_oe = 1'b0;
      #110 o_scl = 1'b1;
      #100 o_sda_oe = 1'b1;
      #100 o_scl = 1'b0;
   end
   endtask

   task stop;
   begin
      #140 o_sda_oe = 1'b1;
      #110 o_scl = 1'b1;
      #100 o_sda_oe = 1'b0;
   end
   endtask

   task bit_x(input logic b, output logic r);
   begin
      #140 o_sda_oe = ~b;
      #110 o_scl = 1'b1;
      #70 r = i_sda;
      #80 o_scl = 1'b0;
   end
   endtask

   // Only whole bytes go out, so underflow-ended packets are byte padded
   task byte_x(input logic [7:0] d, output logic [7:0] q, output logic ack);
      int k;
   begin
      for (k = 7; k >= 0; k--)
         bit_x(d[k], q[k]);
      bit_x(1'b1, ack);
   end
   endtask
endmodule // tpf_host_model

// File: tb_tx_packet_fifo_control.sv
`timescale 1ns/1ps
module tb_tx_packet_fifo_control;
   logic        i_clk;
   logic        i_rst;
   logic        i_bit_req;
   wire         scl;
   wire         m_oe;
   wire         d_oe;
   wire         sda;
   wire         tx_bit;
   wire         bit_valid;
   wire         tx_active;
   int          err_count = 0;
   int          checks_done = 0;
   logic [7:0]  q;
   logic        a;
   logic [63:0] bits;
   int          nv;

   // Pull-up wins unless a party pulls low
   assign sda = ~(m_oe | d_oe);

   tpf_host_model host (.i_sda(sda), .o_scl(scl), .o_sda_oe(m_oe));
   tpf_tx_fifo dut
   (
      .i_clk(i_clk), .i_rst(i_rst), .i_scl(scl), .i_sda(sda), .o_sda_out(),
      .o_sda_oe(d_oe), .i_bit_req(i_bit_req), .o_tx_bit(tx_bit),
      .o_bit_valid(bit_valid), .o_tx_active(tx_active)
   );

   initial
   begin
      i_clk = 1'b0;
      forever #25 i_clk = ~i_clk;
   end

   task stop_test;
   begin
      $display("checks %0d mismatches %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   end
   endtask

   task chk(input string n, input logic [63:0] e, input logic [63:0] g);
   begin
      checks_done++;
      if (g !== e)
      begin
         err_count++;
         $display("wrong value %s expected %h seen %h", n, e, g);
      end
   end
   endtask

   task wr(input logic [7:0] r, input logic [7:0] d, input int n);
      logic [7:0] v;
   begin
      v = d;
      host.start;
      host.byte_x(8'h54, q, a);
      chk("address ack", 0, a);
      host.byte_x(r, q, a);
      repeat (n)
      begin
         host.byte_x(v, q, a);
         v = v + 8'h29;
      end
      host.stop;
   end
   endtask

   task rd(input string n, input logic [7:0] r, input logic [7:0] e);
   begin
      host.start;
      host.byte_x(8'h54, q, a);
      host.byte_x(r, q, a);
      host.start;
      host.byte_x(8'h55, q, a);
      host.byte_x(8'hFF, q, a);
      host.stop;
      chk(n, e, q);
   end
   endtask

   // Two-byte read; master acks the first byte so the target sends the next register
   task rd_pair(input logic [7:0] r, input logic [15:0] e);
      logic [15:0] w;
      int          k;
   begin
      w = 16'h0000;
      host.start;
      host.byte_x(8'h54, q, a);
      host.byte_x(r, q, a);
      host.start;
      host.byte_x(8'h55, q, a);
      for (k = 0; k < 8; k++)
      begin
         host.bit_x(1'b1, a);
         w = {w[14:0], a};
      end
      host.bit_x(1'b0, a);
      host.byte_x(8'hFF, q, a);
      host.stop;
      w = {w[7:0], q};
      chk("burst read", e, w);
   end
   endtask

   // Back-to-back requests; strobe seen one cycle after each
   task pull(input int n);
      int k;
   begin
      bits = 0;
      nv = 0;
      for (k = 0; k <= n; k++)
      begin
         @(negedge i_clk);
         i_bit_req = (k < n);
         if (k > 0 && bit_valid === 1'b1)
         begin
            bits = {bits[62:0], tx_bit};
            nv++;
         end
      end
   end
   endtask

   task t_reset;
   begin
      rd("length low", 8'h12, 8'hFF);
      rd("length high", 8'h11, 8'h00);
      rd("status", 8'h16, 8'h20);
      host.start;
      host.byte_x(8'h56, q, a);
      host.stop;
      chk("foreign address nack", 1, a);
      // Short length left in place: mode clear must still ignore it
      wr(8'h11, 8'h00, 2);
      rd("length low", 8'h12, 8'h29);
      $display("test reset done");
   end
   endtask

   task t_fill;
   begin
      wr(8'h13, 8'h3C, 8);
      rd("status", 8'h16, 8'h57);
      chk("active", 0, tx_active);
      $display("test fill done");
   end
   endtask

   task t_under;
      logic [63:0] e;
      logic [7:0]  v;
   begin
      e = 0;
      v = 8'h3C;
      repeat (7)
      begin
         e = {e[55:0], v};
         v = v + 8'h29;
      end
      wr(8'h0A, 8'h04, 1);
      rd("enable alias", 8'h10, 8'h04);
      pull(57);
      chk("bits", e, bits);
      chk("bit count", 56, nv);
      chk("active", 0, tx_active);
      rd("done", 8'h14, 8'h80);
      rd("sent low", 8'h15, 8'h38);
      rd("status", 8'h16, 8'hE0);
      rd_pair(8'h14, 16'h8038);
      $display("test underrun done");
   end
   endtask

   task t_len;
   begin
      wr(8'h11, 8'h80, 1);
      wr(8'h12, 8'h0C, 1);
      wr(8'h13, 8'hC3, 2);
      pull(13);
      chk("bits", 64'hC3E, bits);
      chk("bit count", 12, nv);
      rd("done", 8'h14, 8'h80);
      rd("sent low", 8'h15, 8'h0C);
      // One byte against a 12-bit length: underrun ends it first
      wr(8'h13, 8'h96, 1);
      pull(10);
      chk("short bits", 8'h96, bits);
      chk("short count", 8, nv);
      rd("short sent", 8'h15, 8'h08);
      $display("test length done");
   end
   endtask

   task t_soft;
   begin
      wr(8'h17, 8'h01, 1);
      wr(8'h12, 8'h00, 1);
      rd("length low", 8'h12, 8'hFF);
      rd("status", 8'h16, 8'h20);
      wr(8'h17, 8'h00, 1);
      wr(8'h13, 8'h5A, 1);
      pull(1);
      chk("idle bits", 0, nv);
      wr(8'h10, 8'h04, 1);
      pull(9);
      chk("bits", 8'h5A, bits);
      rd("status", 8'h16, 8'hA0);
      $display("test soft reset done");
   end
   endtask

   initial
   begin
      #3000000;
      err_count++;
      stop_test;
   end

   initial
   begin
      i_rst = 1'b1;
      i_bit_req = 1'b0;
      repeat (3) @(negedge i_clk);
      i_rst = 1'b0;
      repeat (3) @(negedge i_clk);
      t_reset;
      t_fill;
      t_under;
      t_len;
      t_soft;
      stop_test;
   end
endmodule // tb_tx_packet_fifo_control
